/* rtl/gpp_pkg.sv */
// Purpose: Constants and carriers for the shared-pin port block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Peripheral control fields arrive as plain inputs
package gpp_pkg;
    // ****************************************
    // Register map (byte offsets)
    // ****************************************
    localparam logic [3:0] OFS_P8_DIR = 4'h0;
    localparam logic [3:0] OFS_P8_DATA = 4'h4;
    localparam logic [3:0] OFS_PB_IN = 4'h8;
    localparam int OFS_W = 4;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int P8_LSB = 5;
    localparam int P8_N = 3;
    localparam int PB_N = 8;
    localparam int P7_N = 8;
    localparam logic [7:0] P8_RSVD_ONES = 8'h1F;
    localparam logic [P8_N-1:0] P8_RESET = 3'h0;
    localparam logic [3:0] OS_OFF = 4'h0;
    // Port 7 pin positions
    localparam int P7_SCK = 0;
    localparam int P7_RXD = 1;
    localparam int P7_TXD = 2;
    localparam int P7_TRS = 4;
    localparam int P7_TCK = 5;
    localparam int P7_TMO = 6;
    // Unbonded port 7 positions
    localparam int P7_RSV_LO = 3;
    localparam int P7_RSV_HI = 7;
    // Voltage-detect comparison pins of port B
    localparam int PB_EXT_LO = 6;
    localparam int PB_EXT_HI = 7;
    // Synchroniser vector layout
    localparam int S_P8 = 0;
    localparam int S_PB = P8_N;
    localparam int S_P7 = P8_N + PB_N;
    localparam int NSYNC = P8_N + PB_N + P7_N;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [3:0] timer_output_select_field;
        logic timer_compare_out;
        logic tx_pin_select;
        logic tx_data;
        logic rx_enable_bit;
        logic clk_src_external;
        logic clk_out_enable;
        logic sync_mode;
        logic serial_clock_out;
    } gpp_p7_ctrl_t;

    typedef struct packed {
        logic [P7_N-1:0] port7_direction;
        logic [P7_N-1:0] port7_data;
    } gpp_p7_gpio_t;

    typedef struct packed {
        logic scan;
        logic [2:0] channel;
        logic ext_compare_sel;
    } gpp_analog_t;

    typedef struct packed {
        logic timer_ext_clock;
        logic timer_ext_reset;
        logic rx_data;
        logic serial_clock_in;
        logic [P7_N-1:0] pin_level;
    } gpp_p7_feed_t;

    typedef struct packed {
        logic [P8_N-1:0] dir8;
        logic [P8_N-1:0] dat8;
        logic wr_pend;
        logic [OFS_W-1:0] wr_ofs;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] filt;
        logic [P8_N-1:0] p8_out;
        logic [P8_N-1:0] p8_oe;
        logic [P7_N-1:0] p7_out;
        logic [P7_N-1:0] p7_oe;
        gpp_p7_feed_t feed;
    } gpp_state_t;
endpackage

/* rtl/gpp_top.sv */
// Purpose: Shared-pin logic for a 6-pin, a 3-bit and an 8-bit port
// Assumes: Pins are asynchronous; peripheral controls share hclk
// Notes: All outputs registered except hresp, tied to 0; pin mux lags controls by one cycle
// Notes: Pin reads lag the pins by four to five edges
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
module gpp_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [gpp_pkg::P8_N-1:0] p8_pin_in,
    output logic [gpp_pkg::P8_N-1:0] p8_pin_out,
    output logic [gpp_pkg::P8_N-1:0] p8_pin_oe,
    input wire logic [gpp_pkg::PB_N-1:0] pb_pin_in,
    input wire gpp_pkg::gpp_analog_t analog_sel,
    input wire logic [gpp_pkg::P7_N-1:0] p7_pin_in,
    output logic [gpp_pkg::P7_N-1:0] p7_pin_out,
    output logic [gpp_pkg::P7_N-1:0] p7_pin_oe,
    input wire gpp_pkg::gpp_p7_gpio_t p7_gpio,
    input wire gpp_pkg::gpp_p7_ctrl_t p7_ctrl,
    output gpp_pkg::gpp_p7_feed_t p7_feed
);
    import gpp_pkg::*;

    gpp_state_t r;
    gpp_state_t n;
    logic [P8_N-1:0] p8_lvl;
    logic [PB_N-1:0] pb_lvl;
    logic [PB_N-1:0] claimed;
    logic [7:0] p8_rd;
    logic [7:0] pb_rd;
    logic [31:0] rd;
    logic take;
    logic sck_in_mode;
    logic sck_out_mode;
    logic wr_dir;
    logic wr_dat;
    logic [P8_N-1:0] dir8_now;
    logic [P8_N-1:0] dat8_now;
    logic [P8_N-1:0] p8_bits;
    logic [PB_N-1:0] pb_bits;
    logic [NSYNC-1:0] filt_nx;

    assign p8_lvl = r.filt[S_P8 +: P8_N];
    assign pb_lvl = r.filt[S_PB +: PB_N];

    // ****************************************
    // Analog claim decode for port B
    // ****************************************
    // Scan mode claims channels of the selected group up to the index
    genvar g;
    generate
        for (g = 0; g < PB_N; g++) begin : g_claim
            localparam logic [2:0] IDX = 3'(g);
            logic hit;
            logic ext;
            assign hit = analog_sel.scan ?
                (IDX[2] == analog_sel.channel[2]) &&
                (IDX[1:0] <= analog_sel.channel[1:0]) :
                (IDX == analog_sel.channel);
            // Comparison inputs sit on the top two pins
            assign ext = analog_sel.ext_compare_sel &&
                (g == PB_EXT_LO || g == PB_EXT_HI);
            assign claimed[g] = hit || ext;
        end
    endgenerate

    // ****************************************
    // Serial clock pin mode and bus take
    // ****************************************
    // External clock source outranks the output modes
    assign sck_in_mode = p7_ctrl.clk_src_external;
    assign sck_out_mode = !p7_ctrl.clk_src_external &&
        (p7_ctrl.clk_out_enable || p7_ctrl.sync_mode);
    // Slave is always ready, so a take is one edge
    assign take = hsel && htrans[1] && hready;

    // ****************************************
    // Post-write register view
    // ****************************************
    // A read right behind a write must see the new value
    assign wr_dir = r.wr_pend && (r.wr_ofs == OFS_P8_DIR);
    assign wr_dat = r.wr_pend && (r.wr_ofs == OFS_P8_DATA);
    assign dir8_now = wr_dir ? hwdata[P8_LSB +: P8_N] : r.dir8;
    assign dat8_now = wr_dat ? hwdata[P8_LSB +: P8_N] : r.dat8;

    // ****************************************
    // Per-bit read muxes and input filter
    // ****************************************
    genvar b;
    generate
        for (b = 0; b < P8_N; b++) begin : g_p8_rd
            // Output bits echo the latch, inputs show the pin
            assign p8_bits[b] = dir8_now[b] ?
                dat8_now[b] : p8_lvl[b];
        end

        for (b = 0; b < PB_N; b++) begin : g_pb_rd
            assign pb_bits[b] = claimed[b] ? 1'b0 : pb_lvl[b];
        end

        for (b = 0; b < NSYNC; b++) begin : g_filt
            // Hold the old level while the last two stages disagree
            assign filt_nx[b] = (r.s2[b] == r.s3[b]) ?
                r.s3[b] : r.filt[b];
        end
    endgenerate

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        n = r;
        p8_rd = P8_RSVD_ONES;
        pb_rd = '0;
        rd = '0;

        // ****************************************
        // Pin sampling
        // ****************************************
        // Three stages; a change counts once stages 2 and 3 agree
        n.s1 = {p7_pin_in, pb_pin_in, p8_pin_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = filt_nx;

        // ****************************************
        // Write data phase
        // ****************************************
        // Stored one cycle after the address phase was taken
        n.wr_pend = 1'b0;
        if (r.wr_pend) begin
            unique case (r.wr_ofs)
                OFS_P8_DIR: begin
                    n.dir8 = hwdata[P8_LSB +: P8_N];
                end
                OFS_P8_DATA: begin
                    n.dat8 = hwdata[P8_LSB +: P8_N];
                end
                default: begin
                    // Port B and unmapped offsets ignore writes
                    n.dir8 = r.dir8;
                end
            endcase
        end

        // ****************************************
        // Read data
        // ****************************************
        // Reserved low bits keep their ones pattern
        p8_rd[P8_LSB +: P8_N] = p8_bits;
        pb_rd = pb_bits;

        // ****************************************
        // Address phase
        // ****************************************
        // Read data is loaded here and stands through the data phase
        if (take) begin
            n.wr_pend = hwrite;
            n.wr_ofs = haddr[OFS_W-1:0];
            unique case (haddr[OFS_W-1:0])
                OFS_P8_DATA: rd = {24'h000000, p8_rd};
                OFS_PB_IN: rd = {24'h000000, pb_rd};
                // Direction is write-only and reads zero
                default: rd = '0;
            endcase
            n.hrdata = hwrite ? r.hrdata : rd;
        end
        n.hreadyout = 1'b1;

        // ****************************************
        // Three-bit port drivers
        // ****************************************
        // Driven from stored values; the pins follow a cycle later
        n.p8_oe = r.dir8;
        n.p8_out = r.dat8;

        // ****************************************
        // Port 7: general I/O baseline
        // ****************************************
        // Every pin starts under its direction and data bits
        n.p7_oe = p7_gpio.port7_direction;
        n.p7_out = p7_gpio.port7_data;

        // Unbonded positions stay quiet
        n.p7_oe[P7_RSV_LO] = 1'b0;
        n.p7_out[P7_RSV_LO] = 1'b0;
        n.p7_oe[P7_RSV_HI] = 1'b0;
        n.p7_out[P7_RSV_HI] = 1'b0;

        // ****************************************
        // Port 7: timer compare pin
        // ****************************************
        // Any nonzero select hands the pin to the timer
        if (p7_ctrl.timer_output_select_field != OS_OFF) begin
            n.p7_oe[P7_TMO] = 1'b1;
            n.p7_out[P7_TMO] = p7_ctrl.timer_compare_out;
        end else begin
            // Select zero leaves the general I/O baseline in place
            n.p7_oe[P7_TMO] = p7_gpio.port7_direction[P7_TMO];
            n.p7_out[P7_TMO] = p7_gpio.port7_data[P7_TMO];
        end

        // ****************************************
        // Port 7: timer clock and reset pins
        // ****************************************
        // No override: the timer only listens, the port may drive
        n.p7_oe[P7_TCK] = p7_gpio.port7_direction[P7_TCK];
        n.p7_out[P7_TCK] = p7_gpio.port7_data[P7_TCK];
        n.p7_oe[P7_TRS] = p7_gpio.port7_direction[P7_TRS];
        n.p7_out[P7_TRS] = p7_gpio.port7_data[P7_TRS];

        // ****************************************
        // Port 7: serial transmit and receive pins
        // ****************************************
        if (p7_ctrl.tx_pin_select) begin
            n.p7_oe[P7_TXD] = 1'b1;
            n.p7_out[P7_TXD] = p7_ctrl.tx_data;
        end

        // Receiver owns the pin; the stored data bit stays put
        if (p7_ctrl.rx_enable_bit) begin
            n.p7_oe[P7_RXD] = 1'b0;
        end

        // ****************************************
        // Port 7: serial clock pin
        // ****************************************
        // External source wins over any output request
        if (sck_in_mode) begin
            n.p7_oe[P7_SCK] = 1'b0;
        end else if (sck_out_mode) begin
            n.p7_oe[P7_SCK] = 1'b1;
            n.p7_out[P7_SCK] = p7_ctrl.serial_clock_out;
        end

        // ****************************************
        // Port 7: feeds to the peripherals
        // ****************************************
        // Filtered levels, so a driven pin reads back as well
        n.feed.pin_level = r.filt[S_P7 +: P7_N];
        n.feed.timer_ext_clock = r.filt[S_P7+P7_TCK];
        n.feed.timer_ext_reset = r.filt[S_P7+P7_TRS];
        // Idle line level when the receiver does not own the pin
        n.feed.rx_data = p7_ctrl.rx_enable_bit ?
            r.filt[S_P7+P7_RXD] : 1'b1;
        n.feed.serial_clock_in = sck_in_mode ?
            r.filt[S_P7+P7_SCK] : 1'b0;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.dir8 <= P8_RESET;
            r.dat8 <= P8_RESET;
            r.hreadyout <= 1'b1;
            // Receive feed idles high like a quiet line
            r.feed.rx_data <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hreadyout = r.hreadyout;
    // No error responses: every access completes OKAY
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign p8_pin_out = r.p8_out;
    assign p8_pin_oe = r.p8_oe;
    assign p7_pin_out = r.p7_out;
    assign p7_pin_oe = r.p7_oe;
    assign p7_feed = r.feed;
endmodule

/* testbench/gpio_ports_pin_function_mux_tb.sv */
// Purpose: Self-checking bench for the shared-pin port block
// Assumes: Pin inputs settle within six edges
// Notes: Expected values come from bench-side models
`timescale 1ns/10ps
module gpio_ports_pin_function_mux_tb;
    import gpp_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp;
    logic [2:0] p8_pin_in, p8_pin_out, p8_pin_oe, d8, w8;
    logic [2:0] p8_ext = 3'h5, p8_en = 3'h0;
    logic [7:0] pb_pin_in = 8'h0, p7_ext = 8'h0;
    logic [7:0] p7_pin_in, p7_pin_out, p7_pin_oe;
    gpp_analog_t analog_sel = '0;
    gpp_p7_gpio_t p7_gpio = '0;
    gpp_p7_ctrl_t p7_ctrl = '0;
    gpp_p7_feed_t p7_feed;
    int error_cnt = 0, n_compared = 0, i;
    assign p7_pin_in = (p7_pin_oe & p7_pin_out) | (~p7_pin_oe & p7_ext);
    gpp_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .p8_pin_in,
        .p8_pin_out, .p8_pin_oe, .pb_pin_in, .analog_sel, .p7_pin_in,
        .p7_pin_out, .p7_pin_oe, .p7_gpio, .p7_ctrl, .p7_feed);
    gpp_pins u_pins (.hclk, .p8_out(p8_pin_out), .p8_oe(p8_pin_oe), .p8_en,
        .p8_ext, .p8_pin(p8_pin_in));
    initial begin
        forever #4 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Called just after an edge; holds each phase until hready
    task automatic ahb(input logic wr, input logic [3:0] a,
        input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // Bits taken by converter scan or comparison read as 0
    function automatic logic [7:0] claim(input gpp_analog_t a);
        logic [7:0] m;
        for (int n = 0; n < 8; n++) begin
            m[n] = a.scan ? (3'(n) >> 2 == a.channel >> 2 &&
                2'(n) <= a.channel[1:0]) : 3'(n) == a.channel;
        end
        if (a.ext_compare_sel) m[7:6] = 2'h3;
        return m;
    endfunction
    function automatic logic [7:0] p7oe(gpp_p7_gpio_t g, gpp_p7_ctrl_t c);
        logic [7:0] e;
        e = g.port7_direction & 8'h77;
        if (|c.timer_output_select_field) e[6] = 1'b1;
        if (c.tx_pin_select) e[2] = 1'b1;
        if (c.rx_enable_bit) e[1] = 1'b0;
        if (c.clk_src_external) e[0] = 1'b0;
        else if (c.clk_out_enable || c.sync_mode) e[0] = 1'b1;
        return e;
    endfunction
    function automatic logic [7:0] p7out(gpp_p7_gpio_t g, gpp_p7_ctrl_t c);
        logic [7:0] o;
        o = g.port7_data & 8'h77;
        if (|c.timer_output_select_field) o[6] = c.timer_compare_out;
        if (c.tx_pin_select) o[2] = c.tx_data;
        if (!c.clk_src_external && (c.clk_out_enable || c.sync_mode)) begin
            o[0] = c.serial_clock_out;
        end
        return o;
    endfunction
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        void'($urandom(2378));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        p8_en <= 3'h7;
        repeat (6) @(posedge hclk);
        chk(32'(p8_pin_oe), 32'h0);
        ahb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h000000BF);
        ahb(1'b1, 4'h0, 32'h000000E0);
        ahb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0000001F);
        ahb(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            d8 = 3'($urandom);
            w8 = 3'($urandom);
            p8_ext <= 3'($urandom);
            ahb(1'b1, 4'h0, {24'h0, d8, 5'h0});
            ahb(1'b1, 4'h4, {24'h0, w8, 5'h0} | ($urandom & 32'hFFFFFF1F));
            repeat (6) @(posedge hclk);
            chk(32'(p8_pin_oe), 32'(d8));
            chk(32'(p8_pin_out & d8), 32'(w8 & d8));
            ahb(1'b0, 4'h4, 32'h0);
            chk(rd, {24'h0, (d8 & w8) | (~d8 & p8_ext), 5'h1F});
            ahb(1'b0, 4'h0, 32'h0);
            chk(rd, 32'h0);
        end
        $display("three-bit port test done");
        for (i = 0; i < 24; i++) begin
            pb_pin_in <= 8'($urandom);
            analog_sel <= gpp_analog_t'(5'($urandom));
            ahb(1'b1, 4'h8, $urandom);
            chk(32'(hresp), 32'h0);
            chk(32'(hreadyout), 32'h1);
            repeat (6) @(posedge hclk);
            ahb(1'b0, 4'h8, 32'h0);
            chk(rd, {24'h0, pb_pin_in & ~claim(analog_sel)});
        end
        $display("input port test done");
        for (i = 0; i < 24; i++) begin
            p7_ctrl <= gpp_p7_ctrl_t'(12'($urandom) &
                (i[0] ? 12'hFFF : 12'h0FF));
            p7_gpio <= gpp_p7_gpio_t'(16'($urandom));
            p7_ext <= 8'($urandom);
            repeat (8) @(posedge hclk);
            chk(32'(p7_pin_oe), 32'(p7oe(p7_gpio, p7_ctrl)));
            chk(32'({p7_feed.timer_ext_clock, p7_feed.timer_ext_reset}),
                32'(p7_pin_in[5:4]));
            chk(32'(p7_pin_out), 32'(p7out(p7_gpio, p7_ctrl)));
            chk(32'(p7_feed.pin_level), 32'(p7_pin_in));
            chk(32'(p7_feed.rx_data),
                32'(!p7_ctrl.rx_enable_bit | p7_pin_in[1]));
            chk(32'(p7_feed.serial_clock_in),
                32'(p7_ctrl.clk_src_external & p7_pin_in[0]));
        end
        $display("shared pin test done");
        end_of_test();
    end
endmodule

/* testbench/gpp_checker.sv */
// Purpose: Port 7 pin mux and feed checks
// Assumes: Controls and pin outputs share hclk
// Notes: Pin drivers lag controls by one edge
`timescale 1ns/10ps
module gpp_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] p7_pin_in,
    input wire logic [7:0] p7_pin_oe,
    input wire logic [7:0] p7_pin_out,
    input wire gpp_pkg::gpp_p7_gpio_t p7_gpio,
    input wire gpp_pkg::gpp_p7_ctrl_t p7_ctrl,
    input wire gpp_pkg::gpp_p7_feed_t p7_feed
);
    import gpp_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Controls as seen one edge ago, to match the registered mux
    gpp_p7_ctrl_t c;
    gpp_p7_gpio_t g;
    logic v;
    always_ff @(posedge hclk) begin
        v <= hresetn;
        c <= p7_ctrl;
        g <= p7_gpio;
    end
    tmo_timer_a: assert property (v && |c.timer_output_select_field
        |-> p7_pin_oe[6] && p7_pin_out[6] == c.timer_compare_out)
        else $error("timer pin not on compare output");
    tmo_port_a: assert property (v && ~|c.timer_output_select_field
        |-> p7_pin_oe[6] == g.port7_direction[6]) else $error("timer pin dir");
    tck_dir_a: assert property (v
        |-> p7_pin_oe[5:4] == g.port7_direction[5:4]) else $error("timer dir");
    tck_feed_a: assert property ($stable(p7_pin_in[5]) [*7]
        |-> p7_feed.timer_ext_clock == p7_pin_in[5]) else $error("clock feed");
    txd_sel_a: assert property (v && c.tx_pin_select
        |-> p7_pin_oe[2] && p7_pin_out[2] == c.tx_data) else $error("tx pin");
    rxd_in_a: assert property (v && c.rx_enable_bit
        |-> !p7_pin_oe[1]) else $error("rx pin driven");
    sck_in_a: assert property (v && c.clk_src_external
        |-> !p7_pin_oe[0]) else $error("clock pin driven");
    sck_out_a: assert property (v && !c.clk_src_external &&
        (c.clk_out_enable || c.sync_mode) |-> p7_pin_oe[0] &&
        p7_pin_out[0] == c.serial_clock_out) else $error("clock pin out");
    cover property (v && |c.timer_output_select_field);
    cover property (v && c.tx_pin_select && c.rx_enable_bit);
    cover property (v && c.clk_src_external);
endmodule
bind gpp_top gpp_checker u_chk (.hclk, .hresetn, .p7_pin_in, .p7_pin_oe,
    .p7_pin_out, .p7_gpio, .p7_ctrl, .p7_feed);

/* testbench/gpp_pins.sv */
// Purpose: Outside drivers on the three-bit port pins
// Assumes: No pull resistors on these pins
// Notes: Undriven pins toggle so a stale value never passes
`timescale 1ns/10ps
module gpp_pins (
    input wire logic hclk,
    input wire logic [2:0] p8_out,
    input wire logic [2:0] p8_oe,
    input wire logic [2:0] p8_en,
    input wire logic [2:0] p8_ext,
    output logic [2:0] p8_pin
);
    logic [2:0] flip = 3'h0;
    always @(posedge hclk) begin
        flip <= ~flip;
    end
    assign p8_pin = (p8_oe & p8_out) | (~p8_oe & p8_en & p8_ext)
        | (~p8_oe & ~p8_en & flip);
endmodule
